// ---- hw/ddrim_ctrl.sv ----
// controller end: power-up sequence and software mode writes over classic wishbone
// assumes the memory is idle (all banks precharged) whenever software asks for a mode write
`timescale 1ns/1ps
`include "ddrim_regs.svh"
module ddrim_ctrl #(
    parameter int STABLE_CYC = `DDRIM_STABLE_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    ddrim_if.ctrl            link,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    typedef struct packed {
        ddrim_pkg::ddrim_state_e state;
        logic [31:0] cnt;
        logic [1:0]  refs;
        logic [11:0] mode;
        logic        cke;
        logic [2:0]  cmd;
        logic        bank_sel0;
        logic [11:0] addr;
        logic        ack;
        logic [31:0] rdat;
    } ddrim_ctrl_s;

    ddrim_ctrl_s st_q;
    ddrim_ctrl_s st_d;
    logic        wb_req;

    assign wb_req = wb_cyc_i && wb_stb_i && !st_q.ack;

    always_comb begin
        st_d      = st_q;
        st_d.ack  = wb_req;
        st_d.cmd  = ddrim_pkg::DDRIM_CMD_NOP;
        st_d.bank_sel0 = 1'b0;
        st_d.addr = 12'h000;
        st_d.cnt  = (st_q.cnt != 32'h0) ? st_q.cnt - 32'h1 : 32'h0;
        if (wb_req && wb_we_i && wb_adr_i == `DDRIM_ADR_MODE && wb_sel_i[0])
            st_d.mode[7:0] = wb_dat_i[7:0] & 8'h7F;
        else if (wb_req && wb_we_i && wb_adr_i == `DDRIM_ADR_MODE && wb_sel_i[1])
            st_d.mode[11:8] = wb_dat_i[11:8];
        if (wb_req && wb_adr_i == `DDRIM_ADR_MODE)
            st_d.rdat = {20'h0, st_q.mode};
        else if (wb_req && wb_adr_i == `DDRIM_ADR_STATUS)
            // ready only once the lock wait or write gap has run out; a command written earlier is dropped
            st_d.rdat = {27'h0, st_q.state == ddrim_pkg::DDRIM_S_READY && st_q.cnt == 32'h0, st_q.state};
        else
            st_d.rdat = 32'h0;
        if (st_q.cnt == 32'h0) begin
            case (st_q.state)
                ddrim_pkg::DDRIM_S_PWR: begin
                    st_d.cke   = 1'b0;
                    st_d.cnt   = STABLE_CYC;
                    st_d.state = ddrim_pkg::DDRIM_S_NOP;
                end
                ddrim_pkg::DDRIM_S_NOP: begin
                    st_d.cke   = 1'b1;
                    st_d.state = ddrim_pkg::DDRIM_S_PRE1;
                end
                ddrim_pkg::DDRIM_S_PRE1, ddrim_pkg::DDRIM_S_PRE2: begin
                    st_d.cmd   = ddrim_pkg::DDRIM_CMD_PRE;
                    st_d.addr[`DDRIM_AP_BIT] = 1'b1;
                    st_d.cnt   = 32'h1;
                    st_d.state = (st_q.state == ddrim_pkg::DDRIM_S_PRE1) ? ddrim_pkg::DDRIM_S_EMRS
                                                                         : ddrim_pkg::DDRIM_S_REF;
                end
                ddrim_pkg::DDRIM_S_EMRS: begin
                    st_d.cmd   = ddrim_pkg::DDRIM_CMD_MODEW;
                    st_d.bank_sel0 = 1'b1;
                    st_d.cnt   = `DDRIM_MODEW_GAP_CYC;
                    st_d.state = ddrim_pkg::DDRIM_S_MODEW1;
                end
                ddrim_pkg::DDRIM_S_MODEW1: begin
                    st_d.cmd   = ddrim_pkg::DDRIM_CMD_MODEW;
                    st_d.addr  = st_q.mode | (12'h1 << `DDRIM_DLLRST_BIT);
                    st_d.cnt   = `DDRIM_MODEW_GAP_CYC;
                    st_d.refs  = 2'h0;
                    st_d.state = ddrim_pkg::DDRIM_S_PRE2;
                end
                ddrim_pkg::DDRIM_S_REF: begin
                    st_d.cmd   = ddrim_pkg::DDRIM_CMD_REF;
                    st_d.cnt   = 32'h1;
                    st_d.refs  = st_q.refs + 2'h1;
                    if (st_q.refs == 2'(`DDRIM_REFRESH_CNT - 1))
                        st_d.state = ddrim_pkg::DDRIM_S_MODEW2;
                end
                ddrim_pkg::DDRIM_S_MODEW2: begin
                    st_d.cmd   = ddrim_pkg::DDRIM_CMD_MODEW;
                    st_d.addr  = st_q.mode & ~(12'h1 << `DDRIM_DLLRST_BIT);
                    st_d.cnt   = `DDRIM_DLL_LOCK_CYC;
                    st_d.state = ddrim_pkg::DDRIM_S_READY;
                end
                ddrim_pkg::DDRIM_S_READY: begin
                    if (wb_req && wb_we_i && wb_adr_i == `DDRIM_ADR_CMD && wb_dat_i[0])
                        st_d.state = ddrim_pkg::DDRIM_S_USER;
                end
                ddrim_pkg::DDRIM_S_USER: begin
                    st_d.cmd   = ddrim_pkg::DDRIM_CMD_MODEW;
                    st_d.addr  = st_q.mode;
                    st_d.cnt   = `DDRIM_MODEW_GAP_CYC;
                    st_d.state = ddrim_pkg::DDRIM_S_READY;
                end
                default: st_d.state = ddrim_pkg::DDRIM_S_PWR;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q       <= '0;
            st_q.cmd   <= ddrim_pkg::DDRIM_CMD_NOP;
            st_q.mode  <= `DDRIM_MODE_RESET;
            st_q.state <= ddrim_pkg::DDRIM_S_PWR;
        end else begin
            st_q <= st_d;
        end
    end

    // chip select held low from power-up; nop encoding keeps it harmless
    assign link.cke              = st_q.cke;
    assign link.cs_n             = 1'b0;
    assign link.ras_n            = st_q.cmd[2];
    assign link.cas_n            = st_q.cmd[1];
    assign link.we_n             = st_q.cmd[0];
    assign link.bank_select_bit0 = st_q.bank_sel0;
    assign link.bank_select_bit1 = 1'b0;
    assign link.addr             = st_q.addr;
    assign wb_dat_o              = st_q.rdat;
    assign wb_ack_o              = st_q.ack;
endmodule

// ---- hw/ddrim_regs.svh ----
// constants for the ddr init / mode register pair: register addresses, field positions and codes, timing counts
// assumes a 100 MHz system clock shared by both ends
`ifndef DDRIM_REGS_SVH
`define DDRIM_REGS_SVH
`define DDRIM_CLK_MHZ          100
`define DDRIM_STABLE_US        200
`define DDRIM_STABLE_CYC       (`DDRIM_STABLE_US * `DDRIM_CLK_MHZ)
`define DDRIM_DLL_LOCK_CYC     200
`define DDRIM_MODEW_GAP_CYC    2
// power-up mode: burst of 4, sequential, latency code 2; a legal code so nothing reads as reserved
`define DDRIM_MODE_RESET       12'h022
`define DDRIM_REFRESH_CNT      2
`define DDRIM_AP_BIT           10
`define DDRIM_BL_LSB           0
`define DDRIM_BT_BIT           3
`define DDRIM_CL_LSB           4
`define DDRIM_TM_BIT           7
`define DDRIM_DLLRST_BIT       8
`define DDRIM_BL2              3'h1
`define DDRIM_BL4              3'h2
`define DDRIM_BL8              3'h3
`define DDRIM_CL2              3'h2
`define DDRIM_CL25             3'h6
`define DDRIM_ADR_MODE         4'h0
`define DDRIM_ADR_STATUS       4'h4
`define DDRIM_ADR_CMD          4'h8
`endif

// ---- hw/ddrim_pkg.sv ----
// types shared by both ends of the ddr init / mode register pair
package ddrim_pkg;
    // command code {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        DDRIM_CMD_MODEW = 3'h0,
        DDRIM_CMD_REF = 3'h1,
        DDRIM_CMD_PRE = 3'h2,
        DDRIM_CMD_ACT = 3'h3,
        DDRIM_CMD_WR  = 3'h4,
        DDRIM_CMD_RD  = 3'h5,
        DDRIM_CMD_BST = 3'h6,
        DDRIM_CMD_NOP = 3'h7
    } ddrim_cmd_e;
    typedef enum logic [3:0] {
        DDRIM_S_PWR   = 4'h0,
        DDRIM_S_NOP   = 4'h1,
        DDRIM_S_PRE1  = 4'h2,
        DDRIM_S_EMRS  = 4'h3,
        DDRIM_S_MODEW1 = 4'h4,
        DDRIM_S_PRE2  = 4'h5,
        DDRIM_S_REF   = 4'h6,
        DDRIM_S_MODEW2 = 4'h7,
        DDRIM_S_LOCK  = 4'h8,
        DDRIM_S_READY = 4'h9,
        DDRIM_S_USER  = 4'hA,
        DDRIM_S_WAIT  = 4'hB
    } ddrim_state_e;
endpackage

// ---- hw/ddrim_if.sv ----
// command/address link between controller and memory device
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface ddrim_if;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        bank_select_bit0;
    logic        bank_select_bit1;
    logic [11:0] addr;
    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank_select_bit0, bank_select_bit1, addr);
    modport mem  (input  cke, cs_n, ras_n, cas_n, we_n, bank_select_bit0, bank_select_bit1, addr);
endinterface

// ---- hw/ddrim_mem.sv ----
// memory-device end: command decode, mode and extended mode registers, burst address order
// assumes pins are synchronous to clk_sys and sampled on its rising edge
//
// Contract
// - controller holds clock enable low at power-up
// - clock stable 200 us before init
// - then nop and raise clock enable
// - precharge all banks before mode writes
// - extended write enables loop, other bits low
// - mode write with A8 high, wait 200
// - second precharge, either order with loop reset
// - at least two auto refreshes follow
// - final mode write with A8 low
// - mode register undefined until written after extended
// - all low selects mode register load
// - mode write only when idle, clock enabled
// - two cycles after mode write
// - reprogramming allowed when all banks idle
// - fields: length, type, latency, test mode
// - A8 high requests loop reset
// - keep test mode bit low
// - sequential order wraps within aligned block
// - interleave order is start xor counter
// - chip select high masks every command
// - burst lengths 2,4,8, sequential or interleave
// - extended write selected by bank bit0 high
`timescale 1ns/1ps
`include "ddrim_regs.svh"
module ddrim_mem (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    ddrim_if.mem             link,
    input  wire logic        burst_start,
    input  wire logic [2:0]  burst_col,
    output logic      [2:0]  burst_addr,
    output logic             burst_valid,
    output logic      [11:0] mode_value,
    output logic             mode_valid,
    output logic             dll_enabled,
    output logic             dll_reset_seen,
    output logic             mode_reserved,
    output logic             test_mode
);
    typedef struct packed {
        logic [11:0] mode;
        logic        mode_ok;
        logic        emrs_ok;
        logic        dll_en;
        logic        dll_rst;
        logic [2:0]  start;
        logic [2:0]  cnt;
        logic [2:0]  bl_mask;
        logic        interleave;
        logic        busy;
        logic [2:0]  addr;
    } ddrim_mem_s;

    ddrim_mem_s st_q;
    ddrim_mem_s st_d;

    logic       cmd_sel;
    logic       is_modew;
    logic [2:0] bl_code;
    logic [2:0] cl_code;
    logic [2:0] mask;
    logic [2:0] cnt_next;

    // clock enable low freezes decode, as the device input buffers would be off
    assign cmd_sel = link.cke && !link.cs_n;
    assign is_modew = cmd_sel && {link.ras_n, link.cas_n, link.we_n} == ddrim_pkg::DDRIM_CMD_MODEW;
    assign bl_code = st_q.mode[`DDRIM_BL_LSB +: 3];
    assign cl_code = st_q.mode[`DDRIM_CL_LSB +: 3];

    always_comb begin
        st_d = st_q;
        mask = 3'h0;
        cnt_next = st_q.cnt + 3'h1;
        if (is_modew && !link.bank_select_bit0) begin
            st_d.mode    = link.addr;
            st_d.mode_ok = st_q.emrs_ok;
            st_d.dll_rst = link.addr[`DDRIM_DLLRST_BIT];
        end else if (is_modew && link.bank_select_bit0) begin
            st_d.emrs_ok = 1'b1;
            st_d.dll_en  = !link.addr[0];
        end
        if (burst_start) begin
            case (bl_code)
                `DDRIM_BL2: mask = 3'h1;
                `DDRIM_BL4: mask = 3'h3;
                `DDRIM_BL8: mask = 3'h7;
                default:    mask = 3'h0;
            endcase
            st_d.bl_mask    = mask;
            st_d.interleave = st_q.mode[`DDRIM_BT_BIT];
            st_d.start      = burst_col;
            st_d.cnt        = 3'h0;
            st_d.busy       = st_q.mode_ok && mask != 3'h0;
            st_d.addr       = burst_col;
        end else if (st_q.busy) begin
            st_d.cnt = cnt_next;
            if (st_q.interleave)
                st_d.addr = (st_q.start & ~st_q.bl_mask) | ((st_q.start ^ cnt_next) & st_q.bl_mask);
            else
                st_d.addr = (st_q.start & ~st_q.bl_mask) | ((st_q.start + cnt_next) & st_q.bl_mask);
            if (st_q.cnt == st_q.bl_mask)
                st_d.busy = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign burst_addr     = st_q.addr;
    assign burst_valid    = st_q.busy;
    assign mode_value     = st_q.mode;
    assign mode_valid     = st_q.mode_ok;
    assign dll_enabled    = st_q.dll_en;
    assign dll_reset_seen = st_q.dll_rst;
    assign test_mode      = st_q.mode[`DDRIM_TM_BIT];
    assign mode_reserved  = st_q.mode_ok && !((bl_code == `DDRIM_BL2 || bl_code == `DDRIM_BL4 ||
                            bl_code == `DDRIM_BL8) && (cl_code == `DDRIM_CL2 || cl_code == `DDRIM_CL25));
endmodule

// ---- tb/ddrim_monitor.sv ----
// link checker: power-up order, mode write shape and spacing on the controller/memory link
// assumes one clock domain and the raw interface signals as inputs
`timescale 1ns/1ps
module ddrim_monitor #(
    parameter int STABLE_CYC = 20000
) (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic        bank_select_bit0,
    input wire logic        bank_select_bit1,
    input wire logic [11:0] addr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic [31:0] cnt_q;
    logic [1:0]  ref_q;
    logic        pre_q, emrs_q, mw_q, act, mw, emrs;
    logic [2:0]  cmd;
    assign cmd  = {ras_n, cas_n, we_n};
    assign act  = cke && !cs_n;
    assign mw   = act && cmd == 3'h0 && !bank_select_bit0;
    assign emrs = act && cmd == 3'h0 && bank_select_bit0;
    // sticky history flags; refresh count saturates since only two are needed
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            {cnt_q, ref_q, pre_q, emrs_q, mw_q} <= '0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            pre_q <= pre_q || (act && cmd == 3'h2);
            emrs_q <= emrs_q || emrs;
            mw_q <= mw_q || mw;
            if (act && cmd == 3'h1 && ref_q != 2'h2) begin
                ref_q <= ref_q + 2'h1;
            end
        end
    end
    property p_cke_hold; (cnt_q < STABLE_CYC - 1) |-> !cke; endproperty
    a_cke_hold: assert property (p_cke_hold) else $error("clock enable raised early");
    property p_cke_rise; $rose(cke) |-> cmd == 3'h7 && cnt_q >= STABLE_CYC - 1; endproperty
    a_cke_rise: assert property (p_cke_rise) else $error("bad clock enable rise");
    property p_pre_all; act && cmd == 3'h2 |-> addr[10]; endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge not all banks");
    property p_pre_first; mw || emrs |-> pre_q; endproperty
    a_pre_first: assert property (p_pre_first) else $error("mode write before precharge");
    property p_emrs_shape; emrs |-> addr == 12'h000 && !bank_select_bit1; endproperty
    a_emrs_shape: assert property (p_emrs_shape) else $error("bad extended write");
    property p_emrs_first; mw |-> emrs_q; endproperty
    a_emrs_first: assert property (p_emrs_first) else $error("mode write before extended");
    property p_dll_reset; mw && !mw_q |-> addr[8]; endproperty
    a_dll_reset: assert property (p_dll_reset) else $error("first mode write lacks loop reset");
    property p_gap; mw || emrs |=> (cs_n || cmd == 3'h7) [*2]; endproperty
    a_gap: assert property (p_gap) else $error("command too soon after mode write");
    property p_test_low; mw |-> !addr[7]; endproperty
    a_test_low: assert property (p_test_low) else $error("test mode bit set");
    property p_refresh; mw && !addr[8] |-> ref_q == 2'h2; endproperty
    a_refresh: assert property (p_refresh) else $error("final mode write before two refreshes");
    c_emrs: cover property (emrs);
    c_dll: cover property (mw && addr[8]);
    c_ref: cover property (act && cmd == 3'h1);
    c_final: cover property (mw && !addr[8]);
endmodule

// ---- tb/ddrim_bench.sv ----
// self-checking bench: controller and memory joined by the link, software over wishbone
// assumes the memory end decodes every mode write the controller issues
`timescale 1ns/1ps
`include "ddrim_regs.svh"
module ddrim_bench;
    localparam int STABLE = 50;
    logic        clk_sys = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, b_start = 1'b0;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, rd_o, wb_rd, seed = 32'h010FE970;
    logic [2:0]  b_col = 3'h0, b_addr;
    logic [11:0] m_val;
    logic        ack, b_valid, m_valid, dll_en, dll_rst, m_res, t_mode;
    int          n_mismatch = 0, n_compared = 0;
    ddrim_if link ();
    ddrim_ctrl #(.STABLE_CYC(STABLE)) u_ddrim_ctrl (.clk_sys(clk_sys), .srst(srst), .link(link.ctrl),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
        .wb_dat_o(rd_o), .wb_ack_o(ack));
    ddrim_mem u_ddrim_mem (.clk_sys(clk_sys), .srst(srst), .link(link.mem), .burst_start(b_start),
        .burst_col(b_col), .burst_addr(b_addr), .burst_valid(b_valid), .mode_value(m_val),
        .mode_valid(m_valid), .dll_enabled(dll_en), .dll_reset_seen(dll_rst), .mode_reserved(m_res),
        .test_mode(t_mode));
    ddrim_monitor #(.STABLE_CYC(STABLE)) u_mon (.clk_sys(clk_sys), .srst(srst), .cke(link.cke),
        .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .bank_select_bit0(link.bank_select_bit0), .bank_select_bit1(link.bank_select_bit1), .addr(link.addr));
    always #5 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] exp_addr(input int col, input int bl, input logic il, input int i);
        return il ? col ^ i : (col & ~(bl - 1)) | ((col + i) % bl);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_sys);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 40);
        wb_rd = rd_o;
        {cyc, stb} <= 2'b00;
        chk({31'h0, ack}, 32'h1, "wishbone answer");
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            wb(1'b0, 4'h4, 32'h0, 4'hF);
            n++;
        end while (wb_rd[4] !== 1'b1 && n < 200);
        chk(wb_rd, 32'h19, "status ready");
    endtask
    task automatic burst(input int col, input int bl, input logic il);
        logic [31:0] q[$];
        @(posedge clk_sys);
        b_start <= 1'b1;
        b_col <= col[2:0];
        @(posedge clk_sys);
        b_start <= 1'b0;
        repeat (12) begin
            @(posedge clk_sys);
            if (b_valid === 1'b1) q.push_back({29'h0, b_addr});
        end
        chk(q.size(), bl, "burst length");
        foreach (q[k]) chk(q[k], exp_addr(col, bl, il, k), "burst order");
    endtask
    task report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        int          n;
        logic [2:0]  blc;
        logic [11:0] val, ex;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        wb(1'b1, 4'h8, 32'h1, 4'hF);
        chk(m_valid, 1'b0, "command refused during power-up");
        wait_ready();
        chk({m_valid, dll_en, dll_rst, t_mode, m_res}, 5'h18, "after power-up");
        chk(m_val, `DDRIM_MODE_RESET & ~(12'h1 << `DDRIM_DLLRST_BIT), "mode after power-up");
        wb(1'b0, 4'hC, 32'h0, 4'hF);
        chk(wb_rd, 32'h0, "unmapped read");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            // last pass uses the reserved length code: no burst may come out
            blc = (i == 7) ? 3'h0 : 3'(1 + seed[7:0] % 3);
            val = {3'h0, seed[9], seed[10], seed[11] ? 3'h6 : 3'h2, seed[12], blc};
            ex = val & 12'hF7F;
            wb(1'b1, 4'h0, {24'h0, val[7:0]}, 4'h1);
            wb(1'b1, 4'h0, {20'h0, val[11:8], 8'h0}, 4'h2);
            wb(1'b1, 4'hC, 32'hFFF, 4'hF);
            wb(1'b0, 4'h0, 32'h0, 4'hF);
            chk(wb_rd, {20'h0, ex}, "mode readback");
            wb(1'b1, 4'h8, 32'h1, 4'hF);
            n = 0;
            while (m_val !== ex && n < 20) begin
                @(posedge clk_sys);
                n++;
            end
            chk(m_val, ex, "mode load");
            chk({dll_rst, t_mode, m_res}, {ex[8], 1'b0, i == 7}, "mode fields");
            for (int c = 0; c < 8; c++) burst(c, (i == 7) ? 0 : 1 << blc, ex[3]);
            wait_ready();
        end
        report_and_stop();
    end
endmodule
